// *** pkg/cnsc_defines.svh ***
// Constants for the CAN node switch configuration block
`ifndef CNSC_DEFINES_SVH
`define CNSC_DEFINES_SVH

// Register byte offsets
`define CNSC_OFS_CTRL        8'h00
`define CNSC_OFS_CABLE       8'h04
`define CNSC_OFS_STATUS      8'h08
`define CNSC_OFS_RATE        8'h0c

// Field positions
`define CNSC_CTRL_PROTO_BIT  0
`define CNSC_STAT_MISM_BIT   5

// Reset values
`define CNSC_CTRL_RST        1'h0
`define CNSC_CABLE_RST       16'h0014

// Bit rates in kHz
`define CNSC_KHZ_1000        16'h03e8
`define CNSC_KHZ_800         16'h0320
`define CNSC_KHZ_500         16'h01f4
`define CNSC_KHZ_250         16'h00fa

// Timing
`define CNSC_CLK_HZ          40000000
`define CNSC_BLINK_MS        250
`define CNSC_BLINK_CYC       ((`CNSC_CLK_HZ / 1000) * `CNSC_BLINK_MS)

// AXI responses
`define CNSC_RESP_OKAY       2'h0
`define CNSC_RESP_SLVERR     2'h2

`endif

// *** pkg/cnsc_pkg.sv ***
// Types shared by the CAN node switch configuration block
`include "cnsc_defines.svh"

package cnsc_pkg;

   typedef enum logic [1:0] {
      SPD_1000,
      SPD_800,
      SPD_500,
      SPD_250
   } cnsc_speed_t;

   typedef enum logic [1:0] {
      MODE_SAMPLE,
      MODE_NODE,
      MODE_CFG_SELECT,
      MODE_CFG_SAVED
   } cnsc_mode_t;

   typedef struct packed {
      logic stop;
      logic run;
      logic tx;
      logic rx;
   } cnsc_led_t;

   function automatic logic [15:0] cnsc_speed_khz_t(input cnsc_speed_t s);
      logic [15:0] k;
      unique case (s)
         SPD_1000: k = `CNSC_KHZ_1000;
         SPD_800:  k = `CNSC_KHZ_800;
         SPD_500:  k = `CNSC_KHZ_500;
         SPD_250:  k = `CNSC_KHZ_250;
      endcase
      return k;
   endfunction : cnsc_speed_khz_t

endpackage : cnsc_pkg

// *** rtl/cnsc_len_lut.sv ***
// Cable length to proprietary bus rate lookup
`timescale 1ns/1ps
`include "cnsc_defines.svh"

module cnsc_len_lut
   import cnsc_pkg::*;
(
   input  wire logic [15:0] len_m_in,
   output logic      [15:0] rate_khz_out
);
   localparam int N = 12;
   // Longest length in metres served by each row
   localparam logic [15:0] LEN_TAB [N] = '{
      16'h0014, 16'h001e, 16'h0028, 16'h0032, 16'h003c, 16'h0046,
      16'h0050, 16'h005a, 16'h0064, 16'h006e, 16'h0078, 16'h0082};
   // 1000 888 800 727 666 615 571 533 500 480 430 400 kHz
   localparam logic [15:0] RATE_TAB [N] = '{
      `CNSC_KHZ_1000, 16'h0378, `CNSC_KHZ_800, 16'h02d7, 16'h029a,
      16'h0267, 16'h023b, 16'h0215, `CNSC_KHZ_500, 16'h01e0,
      16'h01ae, 16'h0190};

   // Lengths between rows take the next longer row
   always_comb begin
      rate_khz_out = `CNSC_KHZ_250;
      for (int i = N - 1; i >= 0; i--) begin
         if (len_m_in <= LEN_TAB[i]) begin
            rate_khz_out = RATE_TAB[i];
         end
      end
   end
endmodule : cnsc_len_lut

// *** rtl/cnsc_top.sv ***
// CAN node switch configuration loader with AXI4-Lite registers
`timescale 1ns/1ps
`include "cnsc_defines.svh"

module cnsc_top
   import cnsc_pkg::*;
#(
   parameter int ADDR_W    = 7,
   parameter int BLINK_CYC = `CNSC_BLINK_CYC
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_b_in,
   input  wire logic [7:0]        s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   input  wire logic [7:0]        s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [31:0]            s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   input  wire logic [7:0]        dip_sw_in,
   input  wire logic [2:0]        panel_speed_switches_in,
   input  wire logic [1:0]        rack_speed_sw_in,
   input  wire logic [1:0]        nv_speed_in,
   input  wire logic              nv_valid_in,
   output logic                   nv_store_out,
   output logic [1:0]             nv_speed_out,
   output logic                   det_req_out,
   input  wire logic              det_valid_in,
   input  wire logic [1:0]        det_speed_in,
   output logic [ADDR_W-1:0]      node_addr_out,
   output logic                   node_addr_valid_out,
   output logic [1:0]             module_speed_out,
   output logic                   cfg_mode_out,
   output cnsc_led_t              led_out,
   output logic                   panel_proto_out,
   output logic [1:0]             panel_speed_out,
   output logic [1:0]             rack_speed_out,
   output logic                   ctrl_proto_out,
   output logic [15:0]            ctrl_rate_khz_out,
   output logic                   mismatch_out
);
   if (ADDR_W < 1 || ADDR_W > 7) begin : g_chk_addr
      $error("ADDR_W must be 1 to 7");
   end
   if (BLINK_CYC < 1) begin : g_chk_blink
      $error("BLINK_CYC must be at least 1");
   end

   // Configuration state
   cnsc_mode_t          mode_r;
   logic [ADDR_W-1:0]   node_addr_r;
   cnsc_speed_t         module_speed_r;
   logic                nv_valid_r;
   logic                nv_store_r;
   cnsc_speed_t         nv_speed_r;
   logic                panel_proto_r;
   cnsc_speed_t         panel_speed_r;
   cnsc_speed_t         rack_speed_r;
   cnsc_led_t           led_r;
   cnsc_led_t           led_nxt;
   logic [31:0]         blink_cnt_r;
   logic                blink_r;
   // Controller state
   logic                bus_protocol_param_r;
   logic [15:0]         cable_length_param_r;
   logic [15:0]         ctrl_rate_r;
   logic                det_done_r;
   cnsc_speed_t         det_speed_r;
   logic                mismatch_r;
   // Bus slave state
   logic                aw_hold_r;
   logic [7:0]          awaddr_r;
   logic                w_hold_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                bvalid_r;
   logic [1:0]          bresp_r;
   logic                rvalid_r;
   logic [31:0]         rdata_r;
   logic [1:0]          rresp_r;

   // Power-up switch decode
   wire        sampling    = (mode_r == MODE_SAMPLE);
   wire        all_off     = (dip_sw_in == 8'h00);
   wire        sel_ok      = (dip_sw_in[6:2] == 5'h00);
   wire        save_req    = dip_sw_in[7] && sel_ok;
   wire        store_now   = (mode_r == MODE_CFG_SELECT) && save_req;
   wire [1:0]  sel_code    = dip_sw_in[1:0];
   wire cnsc_speed_t sel_speed = cnsc_speed_t'(sel_code);
   wire [1:0]  panel_code  = panel_speed_switches_in[2:1];
   wire cnsc_speed_t panel_dec =
      (panel_code == 2'h3) ? SPD_1000 :
      (panel_code == 2'h2) ? SPD_800  :
      (panel_code == 2'h1) ? SPD_500  : SPD_250;
   wire cnsc_speed_t rack_dec =
      (rack_speed_sw_in == 2'h3) ? SPD_1000 :
      (rack_speed_sw_in == 2'h1) ? SPD_800  : SPD_500;
   wire [ADDR_W-1:0] addr_dec = dip_sw_in[ADDR_W-1:0];

   // Mode and power-up capture
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         mode_r <= MODE_SAMPLE;
      end else begin
         unique case (mode_r)
            MODE_SAMPLE:     mode_r <= all_off ? MODE_CFG_SELECT
                                               : MODE_NODE;
            MODE_NODE:       mode_r <= MODE_NODE;
            MODE_CFG_SELECT: if (store_now) begin
                                mode_r <= MODE_CFG_SAVED;
                             end
            MODE_CFG_SAVED:  mode_r <= MODE_CFG_SAVED;
         endcase
      end
   end

   // Speeds are taken once per reset only
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         node_addr_r    <= '0;
         module_speed_r <= SPD_1000;
         nv_valid_r     <= 1'b0;
         panel_proto_r  <= 1'b0;
         panel_speed_r  <= SPD_250;
         rack_speed_r   <= SPD_500;
      end else if (sampling) begin
         if (!all_off) begin
            node_addr_r <= addr_dec;
         end
         module_speed_r <= cnsc_speed_t'(nv_speed_in);
         nv_valid_r     <= nv_valid_in;
         panel_proto_r  <= panel_speed_switches_in[0];
         panel_speed_r  <= panel_dec;
         rack_speed_r   <= rack_dec;
      end else if (store_now) begin
         nv_valid_r <= 1'b1;
      end
   end

   // Store strobe to nonvolatile storage
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         nv_store_r <= 1'b0;
         nv_speed_r <= SPD_1000;
      end else begin
         nv_store_r <= store_now;
         if (store_now) begin
            nv_speed_r <= sel_speed;
         end
      end
   end

   // Blink timebase
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end else if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_r     <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end

   // Status LEDs
   always_comb begin
      led_nxt = '0;
      unique case (mode_r)
         MODE_CFG_SELECT: begin
            if (!nv_valid_r) begin
               led_nxt.tx = blink_r;
            end else begin
               led_nxt.stop = dip_sw_in[0] & blink_r;
               led_nxt.run  = dip_sw_in[1] & blink_r;
               led_nxt.tx   = dip_sw_in[2] & blink_r;
               led_nxt.rx   = dip_sw_in[3] & blink_r;
            end
         end
         MODE_CFG_SAVED: begin
            if (nv_speed_r == SPD_1000) begin
               led_nxt = 4'hf;
            end else begin
               led_nxt.stop = nv_speed_r[0];
               led_nxt.run  = nv_speed_r[1];
            end
         end
         MODE_SAMPLE, MODE_NODE: led_nxt = '0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         led_r <= '0;
      end else begin
         led_r <= led_nxt;
      end
   end

   // Controller side rate selection
   wire [15:0] lut_khz;

   cnsc_len_lut u_len_lut (
      .len_m_in     (cable_length_param_r),
      .rate_khz_out (lut_khz)
   );

   wire mism_now = bus_protocol_param_r && det_done_r && !sampling &&
                   ((panel_proto_r && panel_speed_r != det_speed_r) ||
                    (rack_speed_r != det_speed_r) ||
                    (mode_r == MODE_NODE && nv_valid_r &&
                     module_speed_r != det_speed_r));

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         det_done_r  <= 1'b0;
         det_speed_r <= SPD_1000;
         ctrl_rate_r <= `CNSC_KHZ_1000;
      end else begin
         if (!bus_protocol_param_r) begin
            det_done_r <= 1'b0;
         end else if (det_valid_in && !det_done_r) begin
            det_done_r  <= 1'b1;
            det_speed_r <= cnsc_speed_t'(det_speed_in);
         end
         ctrl_rate_r <= bus_protocol_param_r
                        ? cnsc_speed_khz_t(det_speed_r)
                        : lut_khz;
      end
   end

   // Register bus decode
   wire       wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
   wire       wr_ctrl   = wr_fire && awaddr_r == `CNSC_OFS_CTRL;
   wire       wr_cable  = wr_fire && awaddr_r == `CNSC_OFS_CABLE;
   wire       wr_status = wr_fire && awaddr_r == `CNSC_OFS_STATUS;
   wire       wr_rate   = wr_fire && awaddr_r == `CNSC_OFS_RATE;
   wire       wr_ok     = wr_ctrl || wr_cable || wr_status || wr_rate;
   wire       mism_clr  = wr_status && wstrb_r[0] &&
                          wdata_r[`CNSC_STAT_MISM_BIT];
   wire       rd_fire   = s_axi_arvalid_in && !rvalid_r;
   wire [31:0] status_word = {18'h0, det_speed_r, rack_speed_r,
                              panel_speed_r, panel_proto_r, det_done_r,
                              mismatch_r, nv_valid_r, module_speed_r,
                              mode_r};
   wire [31:0] rate_word = {8'h0, node_addr_valid_out,
                            (7)'(node_addr_r), ctrl_rate_r};
   wire        rd_hit   = s_axi_araddr_in == `CNSC_OFS_CTRL ||
                          s_axi_araddr_in == `CNSC_OFS_CABLE ||
                          s_axi_araddr_in == `CNSC_OFS_STATUS ||
                          s_axi_araddr_in == `CNSC_OFS_RATE;
   wire [31:0] rd_mux =
      (s_axi_araddr_in == `CNSC_OFS_CTRL)   ? {31'h0, bus_protocol_param_r} :
      (s_axi_araddr_in == `CNSC_OFS_CABLE)  ? {16'h0, cable_length_param_r} :
      (s_axi_araddr_in == `CNSC_OFS_STATUS) ? status_word :
      (s_axi_araddr_in == `CNSC_OFS_RATE)   ? rate_word : 32'h0;

   // Software registers; mismatch set beats its clear
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus_protocol_param_r <= `CNSC_CTRL_RST;
         cable_length_param_r <= `CNSC_CABLE_RST;
         mismatch_r           <= 1'b0;
      end else begin
         if (wr_ctrl && wstrb_r[0]) begin
            bus_protocol_param_r <= wdata_r[`CNSC_CTRL_PROTO_BIT];
         end
         if (wr_cable && wstrb_r[0]) begin
            cable_length_param_r[7:0] <= wdata_r[7:0];
         end
         if (wr_cable && wstrb_r[1]) begin
            cable_length_param_r[15:8] <= wdata_r[15:8];
         end
         if (mism_now) begin
            mismatch_r <= 1'b1;
         end else if (mism_clr) begin
            mismatch_r <= 1'b0;
         end
      end
   end

   // Write channel: address and data in either order
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         aw_hold_r <= 1'b0;
         awaddr_r  <= 8'h00;
         w_hold_r  <= 1'b0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `CNSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata_in;
            wstrb_r  <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ok ? `CNSC_RESP_OKAY : `CNSC_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready_in) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= `CNSC_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_hit ? `CNSC_RESP_OKAY : `CNSC_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end

   // Outputs
   assign s_axi_awready_out   = !aw_hold_r && !bvalid_r;
   assign s_axi_wready_out    = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid_out    = bvalid_r;
   assign s_axi_bresp_out     = bresp_r;
   assign s_axi_arready_out   = !rvalid_r;
   assign s_axi_rvalid_out    = rvalid_r;
   assign s_axi_rdata_out     = rdata_r;
   assign s_axi_rresp_out     = rresp_r;
   assign nv_store_out        = nv_store_r;
   assign nv_speed_out        = nv_speed_r;
   assign det_req_out         = bus_protocol_param_r && !det_done_r;
   assign node_addr_out       = node_addr_r;
   assign node_addr_valid_out = (mode_r == MODE_NODE) &&
                                (node_addr_r != '0);
   assign module_speed_out    = module_speed_r;
   assign cfg_mode_out        = (mode_r == MODE_CFG_SELECT) ||
                                (mode_r == MODE_CFG_SAVED);
   assign led_out             = led_r;
   assign panel_proto_out     = panel_proto_r;
   assign panel_speed_out     = panel_speed_r;
   assign rack_speed_out      = rack_speed_r;
   assign ctrl_proto_out      = bus_protocol_param_r;
   assign ctrl_rate_khz_out   = ctrl_rate_r;
   assign mismatch_out        = mismatch_r;

   // Checks
   property p_addr_load;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (sampling && !all_off) |=>
         (node_addr_r == $past(dip_sw_in[ADDR_W-1:0])) &&
         (mode_r == MODE_NODE);
   endproperty
   a_addr_load: assert property (p_addr_load)
      else $error("node address not loaded from switches");

   property p_cfg_entry;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (sampling && all_off) |=> (mode_r == MODE_CFG_SELECT) ##1 cfg_mode_out;
   endproperty
   a_cfg_entry: assert property (p_cfg_entry)
      else $error("all-off power-up did not enter configuration");

   property p_panel_proto;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      sampling |=> panel_proto_out == $past(panel_speed_switches_in[0]);
   endproperty
   a_panel_proto: assert property (p_panel_proto)
      else $error("panel protocol not taken from switch 1");

   property p_speed_hold;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!sampling && !$past(sampling)) |->
         $stable(panel_speed_out) && $stable(rack_speed_out);
   endproperty
   a_speed_hold: assert property (p_speed_hold)
      else $error("speed changed without reset");

   property p_rack_no250;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      rack_speed_out != SPD_250;
   endproperty
   a_rack_no250: assert property (p_rack_no250)
      else $error("rack module set to 250 kHz");

   property p_tx_only;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode_r == MODE_CFG_SELECT && !nv_valid_r) |=>
         !led_out.stop && !led_out.run && !led_out.rx;
   endproperty
   a_tx_only: assert property (p_tx_only)
      else $error("LEDs other than transmit lit without stored speed");

   property p_store;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      store_now |=> nv_store_out && (nv_speed_out == $past(sel_code))
                    ##1 !nv_store_out && (led_out == (nv_speed_out == 2'h0
                        ? 4'hf : {nv_speed_out[0], nv_speed_out[1], 2'h0}));
   endproperty
   a_store: assert property (p_store)
      else $error("speed store or steady LEDs wrong");

   property p_mismatch;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      mism_now |=> mismatch_out ##1 (mismatch_out || $past(mism_clr));
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("rate mismatch not flagged");

   property p_len_rate;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!bus_protocol_param_r && cable_length_param_r == 16'h0014) |=>
         ctrl_rate_khz_out == `CNSC_KHZ_1000;
   endproperty
   a_len_rate: assert property (p_len_rate)
      else $error("20 m cable did not give 1000 kHz");

   property p_addr_nonzero;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (sampling && dip_sw_in[ADDR_W-1:0] == '0) |=> !node_addr_valid_out;
   endproperty
   a_addr_nonzero: assert property (p_addr_nonzero)
      else $error("node claimed controller address");

endmodule : cnsc_top

// *** verification/cnsc_nv_model.sv ***
// Nonvolatile speed store behind the installer switches
`timescale 1ns/1ps

module cnsc_nv_model (
   input  wire logic       core_clk_in,
   input  wire logic       store_in,
   input  wire logic [1:0] speed_in,
   output logic      [1:0] speed_out = 2'h0,
   output logic            valid_out = 1'b0
);
   always @(posedge core_clk_in)
      if (store_in)
         {valid_out, speed_out} <= {1'b1, speed_in};
endmodule : cnsc_nv_model

// *** verification/can_node_switch_config_tb_top.sv ***
// Self-checking bench for the switch configuration loader
`timescale 1ns/1ps
`include "cnsc_defines.svh"

module can_node_switch_config_tb_top
   import cnsc_pkg::*;
;
   logic        core_clk_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in;
   logic        s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic        s_axi_arready_out, s_axi_rvalid_out, nv_valid_in;
   logic        nv_store_out, det_req_out, det_valid_in, cfg_mode_out;
   logic        node_addr_valid_out, panel_proto_out, ctrl_proto_out;
   logic        mismatch_out;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, dip_sw_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, q, m;
   logic [3:0]  s_axi_wstrb_in = 4'hf;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rack_speed_sw_in, rs;
   logic [1:0]  nv_speed_in, nv_speed_out, det_speed_in, module_speed_out;
   logic [1:0]  panel_speed_out, rack_speed_out;
   logic [2:0]  panel_speed_switches_in;
   logic [6:0]  node_addr_out;
   logic [15:0] ctrl_rate_khz_out;
   logic [7:0]  d, lv;
   cnsc_led_t   led_out;
   int          err_count, samples_checked;

   cnsc_top #(.BLINK_CYC(4)) DUT (
      .core_clk_in, .rst_b_in, .s_axi_awaddr_in,
      .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
      .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
      .s_axi_rready_in, .dip_sw_in, .panel_speed_switches_in,
      .rack_speed_sw_in, .nv_speed_in, .nv_valid_in,
      .nv_store_out, .nv_speed_out, .det_req_out,
      .det_valid_in, .det_speed_in, .node_addr_out,
      .node_addr_valid_out, .module_speed_out, .cfg_mode_out,
      .led_out, .panel_proto_out, .panel_speed_out,
      .rack_speed_out, .ctrl_proto_out, .ctrl_rate_khz_out,
      .mismatch_out);
   cnsc_nv_model NVM (.core_clk_in, .store_in(nv_store_out),
      .speed_in(nv_speed_out), .speed_out(nv_speed_in),
      .valid_out(nv_valid_in));

   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic tk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : tk

   task automatic boot(input logic [7:0] dd, input logic [2:0] p,
                       input logic [1:0] r);
      tk(1);
      rst_b_in <= 1'b0;
      {dip_sw_in, panel_speed_switches_in, rack_speed_sw_in} <= {dd, p, r};
      tk(8);
      rst_b_in <= 1'b1;
      tk(4);
   endtask : boot

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      tk(1);
      {s_axi_awaddr_in, s_axi_wdata_in} <= {a, v};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      repeat (50) begin
         tk(1);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         if (s_axi_bvalid_out) break;
      end
      if (s_axi_bvalid_out !== 1'b1) err_count++;
      if (s_axi_bvalid_out !== 1'b1) summarize();
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      tk(1);
      s_axi_araddr_in <= a;
      {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
      repeat (50) begin
         tk(1);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
         if (s_axi_rvalid_out) break;
      end
      if (s_axi_rvalid_out !== 1'b1) err_count++;
      if (s_axi_rvalid_out !== 1'b1) summarize();
      {q, rs} = {s_axi_rdata_out, s_axi_rresp_out};
      s_axi_rready_in <= 1'b0;
   endtask : rd

   function automatic int len_khz(input int l);
      int r[12] = '{1000, 888, 800, 727, 666, 615, 571, 533, 500, 480,
                    430, 400};
      for (int i = 0; i < 12; i++)
         if (l <= 20 + 10 * i) return r[i];
      return 250;
   endfunction : len_khz

   initial begin
      {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, det_valid_in} = 4'h0;
      {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 3'h0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
      {dip_sw_in, panel_speed_switches_in, rack_speed_sw_in} = 13'h0;
      det_speed_in = 2'h0;
      {err_count, samples_checked} = 64'h0;
      void'($urandom(96));
      for (int i = 0; i < 8; i++) begin
         d = 8'(1 + $urandom % 127);
         boot(d, i[2:0], i[1:0]);
         {panel_speed_switches_in, rack_speed_sw_in} <= ~{i[2:0], i[1:0]};
         tk(2);
         chk({cfg_mode_out, node_addr_out}, {1'b0, d[6:0]});
         chk(node_addr_valid_out, 1'b1);
         chk(panel_proto_out, i[0]);
         chk(panel_speed_out, {~i[2], ~i[1]});
         chk(rack_speed_out, i[0] ? {1'b0, ~i[1]} : 2'h2);
      end
      for (int c = 0; c < 4; c++) begin
         boot(8'h00, 3'h0, 2'h0);
         dip_sw_in <= {6'h00, c[1:0]};
         lv = 8'h0f;
         repeat (12) begin
            tk(1);
            lv = {lv[7:4] | led_out, lv[3:0] & led_out};
         end
         m = (c == 0) ? 32'h120 : {23'h0, 1'b1, c[0], c[1], 6'h0};
         chk({cfg_mode_out, lv}, m);
         dip_sw_in <= {6'h20, c[1:0]};
         for (int n = 0; n < 20 && nv_store_out !== 1'b1; n++) tk(1);
         chk({nv_store_out, nv_speed_out}, {1'b1, c[1:0]});
         tk(3);
         chk(led_out, c == 0 ? 4'hf : {c[0], c[1], 2'h0});
         boot(8'h05, 3'h0, 2'h0);
         chk(module_speed_out, c[1:0]);
      end
      boot(8'h80, 3'h0, 2'h0);
      chk({cfg_mode_out, node_addr_valid_out}, 2'h0);
      wr(`CNSC_OFS_CTRL, 32'h0);
      for (int k = 0; k < 6; k++) begin
         m = (k == 0) ? 32'd90 : $urandom % 160;
         wr(`CNSC_OFS_CABLE, m);
         rd(`CNSC_OFS_RATE);
         chk(q[15:0], len_khz(m));
      end
      rd(8'h10);
      chk({rs, q}, {`CNSC_RESP_SLVERR, 32'h0});
      wr(8'h10, 32'h1);
      chk(rs, `CNSC_RESP_SLVERR);
      wr(`CNSC_OFS_CTRL, 32'h1);
      chk(rs, `CNSC_RESP_OKAY);
      tk(2);
      chk({ctrl_proto_out, det_req_out}, 2'h3);
      {det_valid_in, det_speed_in} <= 3'h6;
      tk(1);
      det_valid_in <= 1'b0;
      tk(3);
      chk(ctrl_rate_khz_out, `CNSC_KHZ_500);
      chk({det_req_out, mismatch_out}, 2'h1);
      rd(`CNSC_OFS_STATUS);
      chk({q[13:12], q[5]}, 3'h5);
      wr(`CNSC_OFS_STATUS, 32'h20);
      chk(mismatch_out, 1'b1);
      wr(`CNSC_OFS_CTRL, 32'h0);
      wr(`CNSC_OFS_STATUS, 32'h20);
      chk({det_req_out, mismatch_out}, 2'h0);
      summarize();
   end
endmodule : can_node_switch_config_tb_top
